//--- dv/oag_core_asserts.sv
// Concurrent checks on the ports of the operand address generation core.
// Assumes a bind to oag_core and a register file that answers within the read cycle.
`timescale 1ns/1ns
module oag_core_asserts
#(
    parameter AW = 16
)
(
    input wire          clock,
    input wire          resetn,
    input wire          start,
    input wire [7:0]    mode,
    input wire [2:0]    op_class,
    input wire [1:0]    ptr_target,
    input wire          pair_op,
    input wire [7:0]    field8,
    input wire [3:0]    index_field,
    input wire [15:0]   field16,
    input wire [AW-1:0] next_pc,
    input wire [7:0]    group_ptr,
    input wire [7:0]    rf_rdata,
    input wire          busy,
    input wire          rf_rd,
    input wire [7:0]    rf_raddr,
    input wire          done,
    input wire          illegal,
    input wire [7:0]    reg_addr,
    input wire [15:0]   operand,
    input wire [AW-1:0] mem_addr,
    input wire [1:0]    mem_space,
    input wire          mem_valid,
    input wire [AW-1:0] target_pc,
    input wire          pc_load
);
    wire take = start && !busy;
    wire rel_cls = op_class == 3'h4 || op_class == 3'h5;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    chk_abs_target: assert property (
        take && mode == 8'h10 && (op_class == 3'h2 || op_class == 3'h3)
        |=> done && pc_load && target_pc == $past(field16)) else $error("absolute target wrong");
    chk_rel_target: assert property (
        take && mode == 8'h20 && rel_cls |=> done && pc_load
        && target_pc == $past(next_pc) + {{(AW-8){$past(field8[7])}}, $past(field8)})
        else $error("relative target wrong");
    chk_rel_refused: assert property (
        take && mode == 8'h20 && !rel_cls |=> done && illegal && !pc_load)
        else $error("offset mode accepted for wrong class");
    chk_pc_load_clean: assert property (
        pc_load |-> done && !illegal) else $error("pc load without clean done");
    chk_work_addr: assert property (
        take && mode == 8'h02 |=> rf_rd && rf_raddr == {$past(group_ptr[7:4]), $past(field8[3:0])})
        else $error("working register address wrong");
    chk_lit_value: assert property (
        take && mode == 8'h40 && pair_op |=> done && operand == $past(field16))
        else $error("literal operand wrong");
    chk_pair_order: assert property (
        take && mode == 8'h04 && pair_op && ptr_target != 2'h0
        |=> rf_rd && !rf_raddr[0] ##1 rf_rd && rf_raddr[0] ##2 done && mem_valid)
        else $error("pair pointer sequence wrong");
    chk_index_sum: assert property (
        take && mode == 8'h08 && op_class == 3'h1
        |=> rf_rd && rf_raddr == {$past(group_ptr[7:4]), $past(index_field)}
        ##1 done && reg_addr == $past(field8, 2) + $past(rf_rdata)) else $error("indexed sum wrong");
    chk_reg_operand: assert property (
        take && mode == 8'h01 && !pair_op |=> rf_rd && rf_raddr == (($past(field8[7:4]) == 4'hE)
        ? {$past(group_ptr[7:4]), $past(field8[3:0])} : $past(field8))
        ##1 done && operand[7:0] == $past(rf_rdata) && reg_addr == $past(rf_raddr))
        else $error("register operand wrong");
endmodule

//--- dv/oag_core_tb.sv
// Self-checking bench for the operand address generation core.
// Assumes oag_core and the checker are compiled alongside; the bench is the register file.
`timescale 1ns/1ns
module oag_core_tb;
    typedef struct {logic [7:0] md; logic [2:0] cl; logic pr; logic [1:0] tg; logic [7:0] f8;
        logic [15:0] f16; int lat; logic il; int kd; logic [15:0] ex;} oag_row_t;
    reg         clock = 1'b0, resetn = 1'b0, start = 1'b0, pair_op = 1'b0;
    reg  [7:0]  mode = 8'h00, field8 = 8'h00, group_ptr = 8'h70, rf_rdata;
    reg  [2:0]  op_class = 3'h0;
    reg  [1:0]  ptr_target = 2'h0;
    reg  [3:0]  index_field = 4'h3;
    reg  [15:0] field16 = 16'h0000, next_pc = 16'h1234;
    wire        busy, rf_rd, done, illegal, mem_valid, pc_load;
    wire [7:0]  rf_raddr, reg_addr;
    wire [15:0] operand, mem_addr, target_pc;
    wire [1:0]  mem_space;
    int         mismatches = 0, checks_done = 0, n, c;
    // Kinds: 0 operand low, 1 reg_addr, 2 target, 3 memory address, 4 operand, 5 refused.
    oag_row_t rows [0:17] = '{
        '{8'h01, 3'h0, 1'b0, 2'h0, 8'hFF, 16'h0000, 2, 1'b0, 0, 16'h00C3},
        '{8'h01, 3'h0, 1'b1, 2'h0, 8'h24, 16'h0000, 4, 1'b0, 4, 16'h1819},
        '{8'h02, 3'h0, 1'b0, 2'h0, 8'h05, 16'h0000, 2, 1'b0, 1, 16'h0075},
        '{8'h04, 3'h0, 1'b0, 2'h0, 8'h44, 16'h0000, 2, 1'b0, 1, 16'h0078},
        '{8'h04, 3'h0, 1'b1, 2'h1, 8'hE6, 16'h0000, 4, 1'b0, 3, 16'h4A4B},
        '{8'h04, 3'h0, 1'b1, 2'h2, 8'h30, 16'h0000, 4, 1'b0, 3, 16'h0C0D},
        '{8'h08, 3'h1, 1'b0, 2'h0, 8'hF0, 16'h0000, 2, 1'b0, 1, 16'h003F},
        '{8'h08, 3'h0, 1'b0, 2'h0, 8'h10, 16'h0000, 1, 1'b1, 5, 16'h0000},
        '{8'h00, 3'h4, 1'b0, 2'h0, 8'h10, 16'h0000, 1, 1'b1, 5, 16'h0000},
        '{8'h10, 3'h2, 1'b0, 2'h0, 8'h00, 16'hABCD, 1, 1'b0, 2, 16'hABCD},
        '{8'h10, 3'h3, 1'b0, 2'h0, 8'h00, 16'hFFFF, 1, 1'b0, 2, 16'hFFFF},
        '{8'h10, 3'h4, 1'b0, 2'h0, 8'h00, 16'h0100, 1, 1'b1, 5, 16'h0000},
        '{8'h20, 3'h4, 1'b0, 2'h0, 8'h80, 16'h0000, 1, 1'b0, 2, 16'h11B4},
        '{8'h20, 3'h5, 1'b0, 2'h0, 8'h7F, 16'h0000, 1, 1'b0, 2, 16'h12B3},
        '{8'h20, 3'h1, 1'b0, 2'h0, 8'h05, 16'h0000, 1, 1'b1, 5, 16'h0000},
        '{8'h20, 3'h3, 1'b0, 2'h0, 8'h05, 16'h0000, 1, 1'b1, 5, 16'h0000},
        '{8'h40, 3'h0, 1'b0, 2'h0, 8'h5A, 16'h0000, 1, 1'b0, 0, 16'h005A},
        '{8'h40, 3'h0, 1'b1, 2'h0, 8'h00, 16'hBEEF, 1, 1'b0, 4, 16'hBEEF}};
    oag_core oag_core_i (.clock(clock), .resetn(resetn), .start(start), .mode(mode),
        .op_class(op_class), .ptr_target(ptr_target), .pair_op(pair_op), .field8(field8),
        .index_field(index_field), .field16(field16), .next_pc(next_pc),
        .group_ptr(group_ptr), .rf_rdata(rf_rdata), .busy(busy), .rf_rd(rf_rd),
        .rf_raddr(rf_raddr), .done(done), .illegal(illegal), .reg_addr(reg_addr),
        .operand(operand), .mem_addr(mem_addr), .mem_space(mem_space),
        .mem_valid(mem_valid), .target_pc(target_pc), .pc_load(pc_load));
    // The register file answers during the read cycle and shows inverted data otherwise.
    always @*
        rf_rdata = rf_rd ? (rf_raddr ^ 8'h3C) : ~(rf_raddr ^ 8'h3C);
    initial
    begin
        forever #2 clock = ~clock;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic launch(input oag_row_t r, input int len = 1);
        mode = r.md;
        op_class = r.cl;
        pair_op = r.pr;
        ptr_target = r.tg;
        field8 = r.f8;
        field16 = r.f16;
        start = 1'b1;
        repeat (len) @(posedge clock);
        #1 start = 1'b0;
        // Fields change once taken: the core must work from what it captured.
        mode = ~r.md;
        field8 = ~r.f8;
        field16 = ~r.f16;
    endtask
    task automatic wait_done;
        n = 1;
        while (done !== 1'b1 && n < 10)
        begin
            @(posedge clock);
            #1 n++;
        end
        if (done !== 1'b1)
        begin
            check("done within bound", 16'h0001, 16'h0000);
            tally_and_finish();
        end
    endtask
    task automatic run_row(input oag_row_t r);
        launch(r);
        wait_done();
        check("latency", 16'(r.lat), 16'(n));
        check("illegal", {15'h0000, r.il}, {15'h0000, illegal});
        case (r.kd)
            0: check("operand low", r.ex, {8'h00, operand[7:0]});
            1: check("reg_addr", r.ex, {8'h00, reg_addr});
            2: check("target_pc", r.ex, pc_load ? target_pc : ~r.ex);
            3: check("mem_addr", r.ex, (mem_valid && mem_space === r.tg) ? mem_addr : ~r.ex);
            4: check("operand", r.ex, operand);
            default: check("pc_load", 16'h0000, {15'h0000, pc_load});
        endcase
        @(posedge clock);
        #1;
    endtask
    initial
    begin
        repeat (5) @(posedge clock);
        #1 check("reset outputs", 16'h0000, operand | target_pc | mem_addr | {8'h00, reg_addr}
            | {busy, done, pc_load, mem_valid, illegal, rf_rd});
        resetn = 1'b1;
        foreach (rows[i])
            run_row(rows[i]);
        launch(rows[4], 2);
        wait_done();
        check("refused start latency", 16'h0003, 16'(n));
        check("refused start address", 16'h4A4B, mem_addr);
        c = 0;
        repeat (4)
        begin
            @(posedge clock);
            #1 c += (done !== 1'b0);
        end
        check("extra done", 16'h0000, 16'(c));
        launch(rows[1]);
        resetn = 1'b0;
        #1 check("mid reset outputs", 16'h0000, operand | {8'h00, reg_addr}
            | {busy, done, rf_rd, mem_valid});
        @(posedge clock);
        #1 resetn = 1'b1;
        run_row(rows[6]);
        tally_and_finish();
    end
endmodule
bind oag_core oag_core_asserts #(.AW(AW)) oag_core_asserts_i (.clock(clock), .resetn(resetn),
    .start(start), .mode(mode), .op_class(op_class), .ptr_target(ptr_target),
    .pair_op(pair_op), .field8(field8), .index_field(index_field), .field16(field16),
    .next_pc(next_pc), .group_ptr(group_ptr), .rf_rdata(rf_rdata), .busy(busy),
    .rf_rd(rf_rd), .rf_raddr(rf_raddr), .done(done), .illegal(illegal),
    .reg_addr(reg_addr), .operand(operand), .mem_addr(mem_addr), .mem_space(mem_space),
    .mem_valid(mem_valid), .target_pc(target_pc), .pc_load(pc_load));

//--- verilog/oag_addr_unit.v
// Combinational register address former for working and indexed operands.
// Assumes the group pointer value is supplied by the register file owner.
`timescale 1ns/1ns

module oag_addr_unit
(
    input  wire [7:0] group_ptr,
    input  wire [7:0] field8,
    input  wire [3:0] index_field,
    input  wire [7:0] index_value,
    output wire [7:0] work_addr,
    output wire [7:0] index_reg_addr,
    output wire [7:0] indexed_addr
);

`include "oag_regs.vh"

    // ----------------------------------------------------------------
    // Address forming
    // ----------------------------------------------------------------
    function [7:0] work_map;
        input [7:0] gp;
        input [3:0] nib;
        begin
            work_map = {gp[`OAG_GP_HI_MSB:`OAG_GP_HI_LSB], nib};
        end
    endfunction

    wire [8:0] sum_w;

    assign work_addr      = work_map(group_ptr, field8[3:0]);
    assign index_reg_addr = work_map(group_ptr, index_field);
    assign sum_w          = {1'b0, field8} + {1'b0, index_value};
    // Carry out of bit 7 is dropped so the result stays in the file.
    assign indexed_addr   = sum_w[7:0];

endmodule

//--- verilog/oag_core.v
// Operand address generation for an 8-bit microcontroller core.
// Assumes a decoder supplies mode, class and fields with a start strobe,
// and a register file answers reads with data within the read cycle.
//
// Notes on behaviour
// - Register-file addresses are eight bits, reaching every location.
// - Memory addresses are sixteen bits taken from register pairs.
// - Working register address is group pointer high nibble over field.
// - Register mode delivers the selected register or pair contents.
// - Pointer mode reads a register and uses it as the address.
// - Memory pointer addresses come from a register pair, never one register.
// - Indexed mode, load only, adds a working register to the field.
// - Absolute mode loads instruction address as next address, jump or call.
// - Offset mode sign-extends an eight-bit displacement and adds it to the PC.
// - The PC added already points past the branching instruction.
// - Offset mode is allowed only for relative jump and decrement branch.
// - Literal operand comes from the instruction field, fetched from program.
`timescale 1ns/1ns

module oag_core
#(
    parameter AW = 16
)
(
    input  wire          clock,
    input  wire          resetn,
    input  wire          start,
    input  wire [7:0]    mode,
    input  wire [2:0]    op_class,
    input  wire [1:0]    ptr_target,
    input  wire          pair_op,
    input  wire [7:0]    field8,
    input  wire [3:0]    index_field,
    input  wire [15:0]   field16,
    input  wire [AW-1:0] next_pc,
    input  wire [7:0]    group_ptr,
    input  wire [7:0]    rf_rdata,
    output wire          busy,
    output reg           rf_rd,
    output reg  [7:0]    rf_raddr,
    output reg           done,
    output reg           illegal,
    output reg  [7:0]    reg_addr,
    output reg  [15:0]   operand,
    output reg  [AW-1:0] mem_addr,
    output reg  [1:0]    mem_space,
    output reg           mem_valid,
    output reg  [AW-1:0] target_pc,
    output reg           pc_load
);

`include "oag_regs.vh"

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_RDHI = 5'h02;
    localparam [4:0] ST_RDLO = 5'h04;
    localparam [4:0] ST_IDX  = 5'h08;
    localparam [4:0] ST_LAST = 5'h10;

    reg  [4:0]    state_q;
    reg  [7:0]    mode_q;
    reg  [1:0]    tgt_q;
    reg           pair_q;
    reg  [7:0]    base_q;
    reg  [7:0]    hi_q;

    wire [7:0]    work_addr;
    wire [7:0]    index_reg_addr;
    wire [7:0]    indexed_addr;
    reg  [7:0]    sel_addr;
    wire [7:0]    even_addr;
    wire [7:0]    unit_field;

    // While busy the unit sees the captured field, so the decoder may move on.
    assign unit_field = busy ? base_q : field8;

    oag_addr_unit oag_addr_unit_i
    (
        .group_ptr      (group_ptr),
        .field8         (unit_field),
        .index_field    (index_field),
        .index_value    (rf_rdata),
        .work_addr      (work_addr),
        .index_reg_addr (index_reg_addr),
        .indexed_addr   (indexed_addr)
    );

    // Busy covers every state but idle, so a start is ignored while it stands.
    assign busy = (state_q != ST_IDLE);

    // Sign extension of an 8-bit displacement to the PC width.
    function [AW-1:0] sext8;
        input [7:0] d;
        begin
            sext8 = {{(AW-8){d[7]}}, d};
        end
    endfunction

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    // A memory pointer always needs two bytes, whatever the pair flag says.
    function needs_pair;
        input       pr;
        input [1:0] tg;
        begin
            needs_pair = pr | (tg != `OAG_TGT_REGFILE);
        end
    endfunction

    // Only the jump and the call may load an absolute target.
    function abs_class_ok;
        input [2:0] cl;
        begin
            abs_class_ok = (cl == `OAG_CLS_ABS_JUMP) || (cl == `OAG_CLS_CALL);
        end
    endfunction

    // Only the relative jump and the decrement branch may add a displacement.
    function rel_class_ok;
        input [2:0] cl;
        begin
            rel_class_ok = (cl == `OAG_CLS_REL_JUMP) || (cl == `OAG_CLS_DEC_BRANCH);
        end
    endfunction

    // Working form in working mode, or when the field carries the working prefix.
    always @*
    begin
        if (mode == `OAG_MODE_WORK4 || field8[7:4] == `OAG_WORK_PREFIX)
            sel_addr = work_addr;
        else
            sel_addr = field8;
    end

    // A pair always begins on the even byte of the pair.
    assign even_addr = {sel_addr[7:1], 1'b0};

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q   <= ST_IDLE;
            mode_q    <= `OAG_MODE_REG8;
            tgt_q     <= `OAG_TGT_REGFILE;
            pair_q    <= 1'b0;
            base_q    <= `OAG_RST_ADDR8;
            hi_q      <= `OAG_RST_ADDR8;
            rf_rd     <= 1'b0;
            rf_raddr  <= `OAG_RST_ADDR8;
            done      <= 1'b0;
            illegal   <= 1'b0;
            reg_addr  <= `OAG_RST_ADDR8;
            operand   <= `OAG_RST_ADDR16;
            mem_addr  <= {AW{1'b0}};
            mem_space <= `OAG_TGT_REGFILE;
            mem_valid <= 1'b0;
            target_pc <= {AW{1'b0}};
            pc_load   <= 1'b0;
        end
        else
        begin
            done      <= 1'b0;
            illegal   <= 1'b0;
            mem_valid <= 1'b0;
            pc_load   <= 1'b0;
            rf_rd     <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        mode_q <= mode;
                        tgt_q  <= ptr_target;
                        pair_q <= needs_pair(pair_op, ptr_target);
                        base_q <= field8;
                        case (mode)
                            `OAG_MODE_REG8, `OAG_MODE_WORK4, `OAG_MODE_POINTER:
                            begin
                                rf_rd <= 1'b1;
                                if (needs_pair(pair_op, ptr_target))
                                    rf_raddr <= even_addr;
                                else
                                    rf_raddr <= sel_addr;
                                state_q <= ST_RDHI;
                            end
                            `OAG_MODE_INDEXED:
                            begin
                                if (op_class == `OAG_CLS_LOAD)
                                begin
                                    rf_rd    <= 1'b1;
                                    rf_raddr <= index_reg_addr;
                                    state_q  <= ST_IDX;
                                end
                                else
                                begin
                                    illegal <= 1'b1;
                                    done    <= 1'b1;
                                end
                            end
                            `OAG_MODE_ABSOLUTE:
                            begin
                                done <= 1'b1;
                                if (abs_class_ok(op_class))
                                begin
                                    target_pc <= field16[AW-1:0];
                                    pc_load   <= 1'b1;
                                end
                                else
                                    illegal <= 1'b1;
                            end
                            `OAG_MODE_PC_OFFSET:
                            begin
                                done <= 1'b1;
                                if (rel_class_ok(op_class))
                                begin
                                    // The caller's PC already points past this instruction.
                                    target_pc <= next_pc + sext8(field8);
                                    pc_load   <= 1'b1;
                                end
                                else
                                    illegal <= 1'b1;
                            end
                            `OAG_MODE_LITERAL:
                            begin
                                // The value comes straight from the fetched instruction bytes.
                                operand <= pair_op ? field16 : {8'h00, field8};
                                done    <= 1'b1;
                            end
                            default:
                            begin
                                illegal <= 1'b1;
                                done    <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_IDX:
                begin
                    // The index register answered during the cycle just ended.
                    reg_addr <= indexed_addr;
                    done     <= 1'b1;
                    state_q  <= ST_IDLE;
                end
                ST_RDHI:
                begin
                    // The even byte of a pair is the high byte.
                    hi_q <= rf_rdata;
                    if (pair_q)
                    begin
                        rf_rd    <= 1'b1;
                        rf_raddr <= {rf_raddr[7:1], 1'b1};
                        state_q  <= ST_RDLO;
                    end
                    else
                    begin
                        operand  <= {8'h00, rf_rdata};
                        reg_addr <= (mode_q == `OAG_MODE_POINTER) ? rf_rdata : rf_raddr;
                        done     <= 1'b1;
                        state_q  <= ST_IDLE;
                    end
                end
                ST_RDLO:
                begin
                    operand <= {hi_q, rf_rdata};
                    state_q <= ST_LAST;
                end
                ST_LAST:
                begin
                    // The pair is complete; hand the address to its space.
                    if (mode_q == `OAG_MODE_POINTER)
                    begin
                        if (tgt_q == `OAG_TGT_REGFILE)
                            reg_addr <= operand[7:0];
                        else
                        begin
                            mem_addr  <= operand[AW-1:0];
                            mem_space <= tgt_q;
                            mem_valid <= 1'b1;
                        end
                    end
                    else
                        reg_addr <= base_q;
                    done    <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    // An unknown state falls back to idle.
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

//--- verilog/oag_regs.vh
// Constants for the operand address generation block.
// Assumes inclusion by the design files of this block only.
`ifndef OAG_REGS_VH
`define OAG_REGS_VH

// ----------------------------------------------------------------
// Addressing mode codes, one-hot
// ----------------------------------------------------------------
`define OAG_MODE_W          8
`define OAG_MODE_REG8       8'h01
`define OAG_MODE_WORK4      8'h02
`define OAG_MODE_POINTER    8'h04
`define OAG_MODE_INDEXED    8'h08
`define OAG_MODE_ABSOLUTE   8'h10
`define OAG_MODE_PC_OFFSET  8'h20
`define OAG_MODE_LITERAL    8'h40

// ----------------------------------------------------------------
// Instruction class codes
// ----------------------------------------------------------------
`define OAG_CLS_W           3
`define OAG_CLS_OTHER       3'h0
`define OAG_CLS_LOAD        3'h1
`define OAG_CLS_ABS_JUMP    3'h2
`define OAG_CLS_CALL        3'h3
`define OAG_CLS_REL_JUMP    3'h4
`define OAG_CLS_DEC_BRANCH  3'h5

// ----------------------------------------------------------------
// Pointer targets
// ----------------------------------------------------------------
`define OAG_TGT_W           2
`define OAG_TGT_REGFILE     2'h0
`define OAG_TGT_PROGRAM     2'h1
`define OAG_TGT_DATA        2'h2

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define OAG_GP_HI_MSB       7
`define OAG_GP_HI_LSB       4
`define OAG_WORK_PREFIX     4'hE
`define OAG_RST_ADDR8       8'h00
`define OAG_RST_ADDR16      16'h0000

`endif
